// ==== include/status_pkg.sv ====
package status_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h0;

	// ****************************************************************
	// accumulators
	// ****************************************************************
	localparam int NUM_ACC = 2;
	localparam int ACC_A = 0;
	localparam int ACC_B = 1;

	// ****************************************************************
	// status word field positions
	// ****************************************************************
	localparam int BIT_A_OVF = 15;
	localparam int BIT_B_OVF = 14;
	localparam int BIT_A_SAT = 13;
	localparam int BIT_B_SAT = 12;
	localparam int BIT_ANY_OVF = 11;
	localparam int BIT_ANY_SAT = 10;
	localparam int BIT_LOOP = 9;
	localparam int BIT_NIB_CARRY = 8;
	localparam int PRIO_LSB = 5;
	localparam int PRIO_W = 3;
	localparam int BIT_REPEAT = 4;
	localparam int FLAGS_LSB = 0;
	localparam int FLAGS_W = 4;
	localparam int BIT_N = 3;
	localparam int BIT_V = 2;
	localparam int BIT_Z = 1;
	localparam int BIT_C = 0;

	// ****************************************************************
	// reset value and half carry positions
	// ****************************************************************
	localparam logic [DATA_W-1:0] STATUS_RST = 16'h0000;
	localparam int BYTE_HC_BIT = 3;
	localparam int WORD_HC_BIT = 7;
	localparam int BYTE_MSB = 7;
	localparam int WORD_MSB = 15;

endpackage

// ==== include/alu_flag_if.sv ====
`timescale 1ns/100ps
interface alu_flag_if;
	logic byte_op;
	logic [15:0] opa;
	logic [15:0] opb;
	logic cin;
	logic n;
	logic ov;
	logic z;
	logic c;
	logic nib_carry;

	modport src
	(
		output byte_op,
		output opa,
		output opb,
		output cin,
		input n,
		input ov,
		input z,
		input c,
		input nib_carry
	);

	modport calc
	(
		input byte_op,
		input opa,
		input opb,
		input cin,
		output n,
		output ov,
		output z,
		output c,
		output nib_carry
	);
endinterface

// ==== core/alu_flag_calc.sv ====
`timescale 1ns/100ps
module alu_flag_calc
(
	alu_flag_if.calc fl
);
	import status_pkg::*;

	// ****************************************************************
	// add flags for byte or word operands
	// ****************************************************************
	logic [4:0] nib_sum;
	logic [8:0] byte_sum;
	logic [16:0] word_sum;

	always_comb
	begin
		nib_sum = {1'b0, fl.opa[3:0]} + {1'b0, fl.opb[3:0]}
			+ {4'h0, fl.cin};
		byte_sum = {1'b0, fl.opa[7:0]} + {1'b0, fl.opb[7:0]}
			+ {8'h00, fl.cin};
		word_sum = {1'b0, fl.opa} + {1'b0, fl.opb} + {16'h0000, fl.cin};
		if (fl.byte_op)
		begin
			// nibble carry for byte operands
			fl.nib_carry = nib_sum[BYTE_HC_BIT+1];
			fl.c = byte_sum[BYTE_MSB+1];
			fl.n = byte_sum[BYTE_MSB];
			fl.z = (byte_sum[7:0] == 8'h00);
			fl.ov = (fl.opa[BYTE_MSB] == fl.opb[BYTE_MSB])
				&& (byte_sum[BYTE_MSB] != fl.opa[BYTE_MSB]);
		end
		else
		begin
			// byte carry for word operands
			fl.nib_carry = byte_sum[WORD_HC_BIT+1];
			fl.c = word_sum[WORD_MSB+1];
			fl.n = word_sum[WORD_MSB];
			fl.z = (word_sum[15:0] == 16'h0000);
			fl.ov = (fl.opa[WORD_MSB] == fl.opb[WORD_MSB])
				&& (word_sum[WORD_MSB] != fl.opa[WORD_MSB]);
		end
	end
endmodule

// ==== core/dsp_core_status_flags.sv ====
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module dsp_core_status_flags
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [status_pkg::ADDR_W-1:0] i_addr,
	input wire logic [status_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [status_pkg::DATA_W-1:0] o_rdata,
	input wire logic [status_pkg::NUM_ACC-1:0] i_acc_wr,
	input wire logic [status_pkg::NUM_ACC-1:0] i_acc_ovf,
	input wire logic [status_pkg::NUM_ACC-1:0] i_acc_sat,
	input wire logic i_loop_running,
	input wire logic i_repeat_active,
	input wire logic i_alu_upd,
	input wire logic i_alu_byte,
	input wire logic [15:0] i_alu_opa,
	input wire logic [15:0] i_alu_opb,
	input wire logic i_alu_cin,
	input wire logic i_nesting_disable,
	input wire logic i_prio_msb,
	output logic [status_pkg::DATA_W-1:0] o_status,
	output logic [status_pkg::PRIO_W-1:0] o_cpu_priority_level,
	output logic o_user_irq_off
);
	import status_pkg::*;

	// ****************************************************************
	// decode and flag calculator
	// ****************************************************************
	logic wr_hit;
	logic rd_hit;
	logic sat_clr_all;
	alu_flag_if fl();

	assign wr_hit = i_wr && (i_addr == STATUS_OFS);
	assign rd_hit = i_rd && (i_addr == STATUS_OFS);
	// a zero in the combined bit wipes both, whatever the others say
	assign sat_clr_all = wr_hit && !i_wdata[BIT_ANY_SAT];
	assign fl.byte_op = i_alu_byte;
	assign fl.opa = i_alu_opa;
	assign fl.opb = i_alu_opb;
	assign fl.cin = i_alu_cin;

	alu_flag_calc u_calc
	(
		.fl(fl)
	);

	// ****************************************************************
	// per accumulator overflow and sticky saturation
	// ****************************************************************
	logic [NUM_ACC-1:0] ovf_q;
	logic [NUM_ACC-1:0] ovf_nq;
	logic [NUM_ACC-1:0] sat_q;
	logic [NUM_ACC-1:0] sat_nq;

	generate
		for (genvar k = 0; k < NUM_ACC; k++)
		begin : g_acc
			logic ovf_r;
			logic ovf_nxt;
			logic sat_r;
			logic sat_nxt;

			always_comb
			begin
				ovf_nxt = ovf_r;
				sat_nxt = sat_r;
				if (i_acc_wr[k])
				begin
					ovf_nxt = i_acc_ovf[k];
				end
				if (sat_clr_all || (wr_hit && !i_wdata[BIT_A_SAT-k]))
				begin
					sat_nxt = 1'b0;
				end
				// set wins over a clear in the same cycle
				if (i_acc_sat[k])
				begin
					sat_nxt = 1'b1;
				end
			end

			always_ff @(posedge i_clk or posedge i_rst)
			begin
				if (i_rst)
				begin
					ovf_r <= 1'b0;
					sat_r <= 1'b0;
				end
				else if (i_ce)
				begin
					ovf_r <= ovf_nxt;
					sat_r <= sat_nxt;
				end
			end

			assign ovf_q[k] = ovf_r;
			assign ovf_nq[k] = ovf_nxt;
			assign sat_q[k] = sat_r;
			assign sat_nq[k] = sat_nxt;
		end
	endgenerate

	// ****************************************************************
	// combined bits, core flags and read port
	// ****************************************************************
	logic any_ovf_r;
	logic any_ovf_nxt;
	logic any_sat_r;
	logic any_sat_nxt;
	logic loop_r;
	logic loop_nxt;
	logic nib_carry_r;
	logic nib_carry_nxt;
	logic [PRIO_W-1:0] prio_r;
	logic [PRIO_W-1:0] prio_nxt;
	logic rep_r;
	logic rep_nxt;
	logic [FLAGS_W-1:0] flags_r;
	logic [FLAGS_W-1:0] flags_nxt;
	logic irq_off_r;
	logic irq_off_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic [DATA_W-1:0] status_word;

	always_comb
	begin
		status_word = STATUS_RST;
		status_word[BIT_A_OVF] = ovf_q[ACC_A];
		status_word[BIT_B_OVF] = ovf_q[ACC_B];
		status_word[BIT_A_SAT] = sat_q[ACC_A];
		status_word[BIT_B_SAT] = sat_q[ACC_B];
		status_word[BIT_ANY_OVF] = any_ovf_r;
		status_word[BIT_ANY_SAT] = any_sat_r;
		status_word[BIT_LOOP] = loop_r;
		status_word[BIT_NIB_CARRY] = nib_carry_r;
		status_word[PRIO_LSB +: PRIO_W] = prio_r;
		status_word[BIT_REPEAT] = rep_r;
		status_word[FLAGS_LSB +: FLAGS_W] = flags_r;
	end

	always_comb
	begin
		any_ovf_nxt = |ovf_nq;
		// derived from the sticky bits, so it can never outlive them
		any_sat_nxt = |sat_nq;
		loop_nxt = i_loop_running;
		rep_nxt = i_repeat_active;
		irq_off_nxt = i_prio_msb;
		nib_carry_nxt = nib_carry_r;
		prio_nxt = prio_r;
		flags_nxt = flags_r;
		if (wr_hit)
		begin
			nib_carry_nxt = i_wdata[BIT_NIB_CARRY];
			flags_nxt = i_wdata[FLAGS_LSB +: FLAGS_W];
			if (!i_nesting_disable)
			begin
				prio_nxt = i_wdata[PRIO_LSB +: PRIO_W];
			end
		end
		// the instruction result beats a software write of the same word
		if (i_alu_upd)
		begin
			nib_carry_nxt = fl.nib_carry;
			flags_nxt = {fl.n, fl.ov, fl.z, fl.c};
		end
		rdata_nxt = '0;
		if (rd_hit)
		begin
			rdata_nxt = status_word;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			any_ovf_r <= 1'b0;
			any_sat_r <= 1'b0;
			loop_r <= 1'b0;
			nib_carry_r <= 1'b0;
			prio_r <= '0;
			rep_r <= 1'b0;
			flags_r <= '0;
			irq_off_r <= 1'b0;
			rdata_r <= '0;
		end
		else if (i_ce)
		begin
			any_ovf_r <= any_ovf_nxt;
			any_sat_r <= any_sat_nxt;
			loop_r <= loop_nxt;
			nib_carry_r <= nib_carry_nxt;
			prio_r <= prio_nxt;
			rep_r <= rep_nxt;
			flags_r <= flags_nxt;
			irq_off_r <= irq_off_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_status = status_word;
	assign o_cpu_priority_level = prio_r;
	assign o_user_irq_off = irq_off_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [4:0] chk_nib;
	logic [8:0] chk_byte;
	logic chk_hc;

	assign chk_nib = {1'b0, i_alu_opa[3:0]} + {1'b0, i_alu_opb[3:0]}
		+ {4'h0, i_alu_cin};
	assign chk_byte = {1'b0, i_alu_opa[7:0]} + {1'b0, i_alu_opb[7:0]}
		+ {8'h00, i_alu_cin};
	assign chk_hc = i_alu_byte ? chk_nib[4] : chk_byte[8];

	a_ovf_follow_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_acc_wr[ACC_A]
		|=> o_status[BIT_A_OVF] == $past(i_acc_ovf[ACC_A]))
		else $error("acc A overflow bit did not follow the write");

	b_ovf_follow_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_acc_wr[ACC_B]
		|=> o_status[BIT_B_OVF] == $past(i_acc_ovf[ACC_B]))
		else $error("acc B overflow bit did not follow the write");

	sat_sticky_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_acc_sat[ACC_A] ##1 (!i_ce || !wr_hit)
		|=> o_status[BIT_A_SAT] && o_status[BIT_ANY_SAT])
		else $error("acc A saturation bit did not stick");

	sat_no_set_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!o_status[BIT_B_SAT] && !i_acc_sat[ACC_B] && wr_hit
		|=> !o_status[BIT_B_SAT])
		else $error("software managed to set acc B saturation");

	any_ovf_or_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_status[BIT_ANY_OVF]
		== (o_status[BIT_A_OVF] || o_status[BIT_B_OVF]))
		else $error("combined overflow is not the OR");

	any_sat_or_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		o_status[BIT_ANY_SAT]
		== (o_status[BIT_A_SAT] || o_status[BIT_B_SAT]))
		else $error("combined saturation is not the OR");

	any_sat_clear_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && wr_hit && !i_wdata[BIT_ANY_SAT] && !(|i_acc_sat)
		|=> !o_status[BIT_A_SAT] && !o_status[BIT_B_SAT])
		else $error("combined clear left an individual bit set");

	loop_bit_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce |=> o_status[BIT_LOOP] == $past(i_loop_running))
		else $error("loop bit does not track the loop");

	half_carry_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_alu_upd |=> o_status[BIT_NIB_CARRY] == $past(chk_hc))
		else $error("half carry does not match the operands");

	reset_zero_a: assert property (
		@(posedge i_clk)
		i_rst |-> o_status == STATUS_RST && o_rdata == '0)
		else $error("status not zero during reset");

	repeat_bit_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce |=> o_status[BIT_REPEAT] == $past(i_repeat_active))
		else $error("repeat bit does not track the input");

	level_lock_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_nesting_disable && wr_hit
		|=> $stable(o_cpu_priority_level))
		else $error("priority level written while locked");

	irq_off_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce ##1 i_ce |=> o_user_irq_off == $past(i_prio_msb, 1))
		else $error("user interrupt disable does not follow level");

	ovf_hold_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		!i_acc_wr[ACC_A] |=> $stable(o_status[BIT_A_OVF]))
		else $error("acc A overflow moved without an acc write");

	read_data_a: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && !i_rd |=> o_rdata == '0)
		else $error("read data stood outside its cycle");
endmodule

// ==== verif/dp_model.sv ====
`timescale 1ns/100ps
// ****************
// datapath partner
// ****************
module dp_model
(
	input wire logic i_clk,
	output logic [1:0] o_acc_wr,
	output logic [1:0] o_acc_ovf,
	output logic [1:0] o_acc_sat,
	output logic o_loop,
	output logic o_rep,
	output logic o_upd,
	output logic o_byte,
	output logic [15:0] o_opa,
	output logic [15:0] o_opb,
	output logic o_cin
);
	initial
	begin
		o_acc_wr = 2'h0;
		o_acc_ovf = 2'h0;
		o_acc_sat = 2'h0;
		o_loop = 1'b0;
		o_rep = 1'b0;
		o_upd = 1'b0;
		o_byte = 1'b0;
		o_opa = 16'h0000;
		o_opb = 16'h0000;
		o_cin = 1'b0;
	end
	// one accumulator write per call
	task automatic acc(input int i, input logic ovf, input logic sat);
		@(posedge i_clk);
		o_acc_wr[i] <= 1'b1;
		o_acc_ovf[i] <= ovf;
		o_acc_sat[i] <= sat;
		@(posedge i_clk);
		o_acc_wr <= 2'h0;
		// stale flag inverted: catches sampling without a write
		o_acc_ovf[i] <= ~ovf;
		o_acc_sat <= 2'h0;
	endtask
	task automatic alu(input logic b, input logic [15:0] a,
		input logic [15:0] c);
		@(posedge i_clk);
		o_upd <= 1'b1;
		o_byte <= b;
		o_opa <= a;
		o_opb <= c;
		@(posedge i_clk);
		o_upd <= 1'b0;
		o_opa <= ~a;
		o_opb <= ~c;
	endtask
	task automatic lvl(input logic lp, input logic rp);
		@(posedge i_clk);
		o_loop <= lp;
		o_rep <= rp;
	endtask
endmodule

// ==== verif/dsp_core_status_flags_tb.sv ====
`timescale 1ns/100ps
module dsp_core_status_flags_tb;
	import status_pkg::*;
	logic clk, rst, ce, wr, rd, nd, prio_msb;
	logic upd, byt, cin, lp, rp, irq_off;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, status, opa, opb, d;
	logic [1:0] awr, aovf, asat;
	logic [2:0] prio;
	int n_errors = 0;
	int cmp_count = 0;
	dp_model i_dp (.i_clk(clk), .o_acc_wr(awr), .o_acc_ovf(aovf),
		.o_acc_sat(asat), .o_loop(lp), .o_rep(rp), .o_upd(upd),
		.o_byte(byt), .o_opa(opa), .o_opb(opb), .o_cin(cin));
	dsp_core_status_flags i_dut (.i_clk(clk), .i_rst(rst), .i_ce(ce),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_acc_wr(awr), .i_acc_ovf(aovf),
		.i_acc_sat(asat), .i_loop_running(lp), .i_repeat_active(rp),
		.i_alu_upd(upd), .i_alu_byte(byt), .i_alu_opa(opa),
		.i_alu_opb(opb), .i_alu_cin(cin), .i_nesting_disable(nd),
		.i_prio_msb(prio_msb), .o_status(status),
		.o_cpu_priority_level(prio), .o_user_irq_off(irq_off));
	// ****************
	// bus and checks
	// ****************
	task automatic wr_w(input logic [3:0] a, input logic [15:0] w);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= w;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_w(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_acc_a();
		i_dp.acc(ACC_A, 1'b1, 1'b1);
		rd_w(STATUS_OFS);
		chk(d, 16'hac00);
		i_dp.acc(ACC_A, 1'b0, 1'b0);
		rd_w(STATUS_OFS);
		chk(d, 16'h2400);
		// read-only and set-by-one attempts all at once
		wr_w(STATUS_OFS, 16'hffff);
		chk(status, 16'h25ef);
	endtask
	task automatic t_acc_b();
		i_dp.acc(ACC_B, 1'b1, 1'b1);
		#1 chk(status, 16'h7c00 | 16'h01ef);
		wr_w(STATUS_OFS, 16'h1400);
		chk(status, 16'h5c00);
		i_dp.acc(ACC_A, 1'b0, 1'b1);
		#1 chk(status, 16'h7c00);
		wr_w(STATUS_OFS, 16'h2000);
		chk(status, 16'h4800);
		i_dp.acc(ACC_B, 1'b0, 1'b0);
		#1 chk(status, 16'h0000);
	endtask
	task automatic t_loop();
		i_dp.lvl(1'b1, 1'b1);
		@(posedge clk);
		#1 chk(status, 16'h0210);
		i_dp.lvl(1'b0, 1'b0);
		@(posedge clk);
		#1 chk(status, 16'h0000);
	endtask
	task automatic hc(input logic b, input logic [15:0] x,
		input logic [15:0] y, input logic e);
		i_dp.alu(b, x, y);
		#1 chk({15'h0, status[BIT_NIB_CARRY]}, {15'h0, e});
	endtask
	task automatic t_ipl();
		wr_w(STATUS_OFS, 16'h00a0);
		chk({13'h0, prio}, 16'h0005);
		@(posedge clk);
		nd <= 1'b1;
		wr_w(STATUS_OFS, 16'h0000);
		rd_w(STATUS_OFS);
		chk(d, 16'h00a0);
		@(posedge clk);
		nd <= 1'b0;
		wr_w(STATUS_OFS, 16'h0000);
		chk(status, 16'h0000);
		@(posedge clk);
		prio_msb <= 1'b1;
		@(posedge clk);
		#1 chk({15'h0, irq_off}, 16'h0001);
		@(posedge clk);
		prio_msb <= 1'b0;
		@(posedge clk);
		#1 chk({15'h0, irq_off}, 16'h0000);
	endtask
	// clock enable low: a write must leave no trace
	task automatic t_ce();
		@(posedge clk);
		ce <= 1'b0;
		wr_w(STATUS_OFS, 16'h010f);
		chk(status, 16'h0000);
		@(posedge clk);
		ce <= 1'b1;
		wr_w(STATUS_OFS, 16'h010f);
		chk(status, 16'h010f);
	endtask
	task automatic t_unmapped();
		wr_w(4'h1, 16'h00ff);
		rd_w(4'h1);
		chk(d, 16'h0000);
		rd_w(STATUS_OFS);
		chk(d, 16'h0000);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// under a hundred cycles expected; far margin
	initial
	begin
		#100us;
		n_errors++;
		end_of_test();
	end
	initial
	begin
		rst = 1'b1;
		{wr, rd, nd, prio_msb} = 4'h0;
		ce = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_w(STATUS_OFS);
		chk(d, STATUS_RST);
		t_acc_a();
		t_acc_b();
		t_loop();
		hc(1'b1, 16'h000f, 16'h0001, 1'b1);
		hc(1'b1, 16'h0008, 16'h0007, 1'b0);
		hc(1'b0, 16'h0080, 16'h0080, 1'b1);
		hc(1'b0, 16'h0008, 16'h0008, 1'b0);
		hc(1'b1, 16'h00ff, 16'h0001, 1'b1);
		chk(status, 16'h0103);
		t_ipl();
		t_unmapped();
		t_ce();
		end_of_test();
	end
endmodule
